/* File: core/can_bsc_params.svh */
// Offsets, field positions, reset values and codes of the buffer status/control block
`ifndef CAN_BSC_PARAMS_SVH
`define CAN_BSC_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BSC_OFS_CTRL 8'h00
`define BSC_OFS_IRQ_STATUS 8'h04
`define BSC_OFS_IRQ_CLEAR 8'h08
`define BSC_OFS_IRQ_ENABLE 8'h0C

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define BSC_DLC_MSB 15
`define BSC_DLC_LSB 12
`define BSC_PRI_MSB 7
`define BSC_PRI_LSB 4
`define BSC_ST_MSB 3
`define BSC_ST_LSB 0
`define BSC_BUSY_BIT 0

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define BSC_ST_RESET 4'h0
`define BSC_PRI_RESET 4'h0
`define BSC_DLC_RESET 4'h0
`define BSC_DLC_MAX_BYTES 4'h8
`define BSC_IRQ_RESET 3'h0
`define BSC_IRQ_BITS 3

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define BSC_RESP_OKAY 2'h0
`define BSC_RESP_SLVERR 2'h2

`endif

/* File: core/can_bsc_pkg.sv */
// Types shared by the buffer status/control block
package can_bsc_pkg;

  // Buffer state codes as held in the state field
  typedef enum logic [3:0] {
    rx_idle = 4'h0,
    rx_idle_busy = 4'h1,
    rx_armed = 4'h2,
    rx_copy_first = 4'h3,
    rx_holding = 4'h4,
    rx_copy_second = 4'h5,
    rx_overwritten = 4'h6,
    rx_copy_repeat = 4'h7,
    tx_idle = 4'h8,
    tx_idle_busy = 4'h9,
    tx_remote_autoreply = 4'hA,
    tx_autoreply_busy_rsvd = 4'hB,
    tx_single_shot = 4'hC,
    tx_busy_single = 4'hD,
    tx_single_then_autoreply = 4'hE,
    tx_busy_autoreply = 4'hF
  } buffer_state_t;

  // Interrupt event positions
  typedef enum logic [1:0] {
    ev_rx_done = 2'h0,
    ev_tx_done = 2'h1,
    ev_wr_reject = 2'h2
  } irq_event_t;

endpackage

/* File: core/dlc_saturate.sv */
// Data length code to transferred byte count, saturating at eight
`timescale 1ns/1ps
`default_nettype none
`include "can_bsc_params.svh"

module dlc_saturate (
  // Code in, byte count out
  input wire logic [3:0] dlc,
  output logic [3:0] byte_count
);

  // Plain binary count; any code of eight or above moves eight bytes
  assign byte_count = (dlc >= `BSC_DLC_MAX_BYTES) ? `BSC_DLC_MAX_BYTES : dlc;

endmodule
`default_nettype wire

/* File: core/can_buffer_status_control.sv */
// Status/control word of one CAN message buffer with AXI4-Lite access
// How it works
// (R1) Word: byte count 15:12, reserved 11:8, priority 7:4, state 3:0.
// (R2) State written by software and advanced by the engine as frames move.
// (R3) While busy, software writes to the buffer are refused except the low byte.
// (R4) Busy is set during a receive copy and while transmission is pending.
// (R5) Every copy-end and transmit-done update clears the busy bit.
// (R6) Copy shows 0011 from armed, 0101 from holding, 0111 from overwritten.
// (R7) Idle 0000, armed 0010, holding 0100, overwritten 0110.
// (R8) 0001 only when software writes idle during a running copy.
// (R9) 1000 is an inactive transmit buffer, 1010 answers remote frames.
// (R10) Single-then-autoreply becomes remote autoreply after it is sent.
// (R11) Pending or sending shows busy single or busy autoreply.
// (R12) 1001 only when software writes transmit idle to a busy buffer.
// (R13) Autoreply code with busy bit is never produced.
// (R14) Priority is kept as software wrote it.
// (R15) Software sets the byte count before requesting transmission.
// (R16) On reception the count of bytes placed is written back.
// (R17) The count is plain binary, 0000 zero bytes to 1000 eight.
// (R18) Never more than eight bytes; codes of eight and above mean eight.
// (R19) Copy end moves armed to holding, an aborted copy (0001) to idle, else to overwritten, clearing busy.
`timescale 1ns/1ps
`default_nettype none
`include "can_bsc_params.svh"

module can_buffer_status_control (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protocol engine events
  input wire logic eng_copy_start,
  input wire logic eng_copy_done,
  input wire logic [3:0] eng_rx_dlc,
  input wire logic eng_remote_hit,
  input wire logic eng_tx_done,
  // Protocol engine view of the buffer
  output logic rx_accepting,
  output logic tx_request,
  output logic [3:0] tx_byte_count,
  output logic [15:0] buffer_status_control,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_rx_armed(input logic [3:0] s);
    return (s == can_bsc_pkg::rx_armed) || (s == can_bsc_pkg::rx_holding) ||
           (s == can_bsc_pkg::rx_overwritten);
  endfunction

  function automatic logic is_tx_busy(input logic [3:0] s);
    return s[3] && s[`BSC_BUSY_BIT] && (s != can_bsc_pkg::tx_autoreply_busy_rsvd);
  endfunction

  // ----------------------------------------
  // Registers and wires
  // ----------------------------------------
  logic [3:0] state_q, state_d;
  logic [3:0] pri_q, pri_d;
  logic [3:0] dlc_q, dlc_d;
  logic [`BSC_IRQ_BITS-1:0] irq_status_q, irq_status_d, irq_enable_q, irq_ev, irq_clr;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q, rdata_q;
  logic [3:0] wr_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic rx_accepting_q, tx_request_q, irq_q;
  logic [3:0] tx_bytes_q;
  logic [3:0] rx_bytes, tx_bytes_d;
  logic wr_fire, ctrl_wr, busy, wr_reject, rx_done_ok, tx_done_ok;

  assign busy = state_q[`BSC_BUSY_BIT];
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign ctrl_wr = wr_fire && (wr_addr_q == `BSC_OFS_CTRL);

  dlc_saturate u_rx_sat (
    .dlc(eng_rx_dlc),
    .byte_count(rx_bytes)
  );

  dlc_saturate u_tx_sat (
    .dlc(dlc_d),
    .byte_count(tx_bytes_d)
  );

  // ----------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------
  // Address and data are taken independently; the response waits for both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_hold_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_hold_q <= 1'b1;
      wr_addr_q <= s_axi_awaddr;
    end else begin
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      awready_q <= !aw_hold_q && !bvalid_q && !wr_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_hold_q <= 1'b0;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_hold_q <= 1'b1;
      wr_data_q <= s_axi_wdata;
      wr_strb_q <= s_axi_wstrb;
    end else begin
      if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
      wready_q <= !w_hold_q && !bvalid_q && !wr_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `BSC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      case (wr_addr_q)
        `BSC_OFS_CTRL, `BSC_OFS_IRQ_CLEAR, `BSC_OFS_IRQ_ENABLE: begin
          bresp_q <= `BSC_RESP_OKAY;
        end
        default: begin
          bresp_q <= `BSC_RESP_SLVERR;
        end
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `BSC_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `BSC_RESP_OKAY;
      case (s_axi_araddr)
        `BSC_OFS_CTRL: begin
          rdata_q <= {16'h0000, dlc_q, 4'h0, pri_q, state_q}; // see (R1)
        end
        `BSC_OFS_IRQ_STATUS: begin
          rdata_q <= {29'h0000_0000, irq_status_q};
        end
        `BSC_OFS_IRQ_ENABLE: begin
          rdata_q <= {29'h0000_0000, irq_enable_q};
        end
        `BSC_OFS_IRQ_CLEAR: begin
          rdata_q <= 32'h0000_0000;
        end
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `BSC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else begin
      arready_q <= !rvalid_q;
    end
  end

  // ----------------------------------------
  // Control word next value
  // ----------------------------------------
  // Engine events are applied after the software write, so an engine update in
  // the same cycle wins over the state that software wrote.
  always_comb begin
    state_d = state_q;
    pri_d = pri_q;
    dlc_d = dlc_q;
    wr_reject = 1'b0;
    rx_done_ok = 1'b0;
    tx_done_ok = 1'b0;
    if (ctrl_wr && wr_strb_q[0]) begin
      pri_d = wr_data_q[`BSC_PRI_MSB:`BSC_PRI_LSB]; // see (R14)
      if (!busy) begin
        case (wr_data_q[`BSC_ST_MSB:`BSC_ST_LSB]) // see (R2)
          can_bsc_pkg::tx_single_shot: begin
            state_d = can_bsc_pkg::tx_busy_single; // see (R4) (R11)
          end
          can_bsc_pkg::tx_single_then_autoreply: begin
            state_d = can_bsc_pkg::tx_busy_autoreply; // see (R4) (R11)
          end
          default: begin
            // Software cannot raise the busy bit by itself
            state_d = {wr_data_q[3:1], 1'b0}; // see (R7) (R9) (R13)
          end
        endcase
      end else if (wr_data_q[2:0] == 3'h0 && wr_data_q[3] == state_q[3]) begin
        // Deactivating a busy buffer keeps busy until the engine finishes; a
        // direction change here would strand the running copy or send, so it is ignored
        state_d = {wr_data_q[3], 3'h1}; // see (R8) (R12)
      end
    end
    if (ctrl_wr && wr_strb_q[1]) begin
      if (busy) begin
        wr_reject = 1'b1; // see (R3)
      end else begin
        dlc_d = wr_data_q[`BSC_DLC_MSB:`BSC_DLC_LSB]; // see (R15)
      end
    end
    if (eng_copy_start && is_rx_armed(state_q)) begin
      state_d = {state_q[3:1], 1'b1}; // see (R4) (R6)
    end else if (eng_copy_done && !state_q[3] && busy) begin
      rx_done_ok = 1'b1;
      dlc_d = rx_bytes; // see (R16) (R17) (R18)
      case (state_q)
        can_bsc_pkg::rx_copy_first: state_d = can_bsc_pkg::rx_holding; // see (R19) (R5)
        can_bsc_pkg::rx_idle_busy: state_d = can_bsc_pkg::rx_idle; // see (R5)
        default: state_d = can_bsc_pkg::rx_overwritten; // see (R19) (R5)
      endcase
    end else if (eng_remote_hit && state_q == can_bsc_pkg::tx_remote_autoreply) begin
      state_d = can_bsc_pkg::tx_busy_autoreply; // see (R11) (R13)
    end else if (eng_tx_done && state_q[3] && busy) begin
      tx_done_ok = 1'b1;
      case (state_q)
        can_bsc_pkg::tx_busy_autoreply: state_d = can_bsc_pkg::tx_remote_autoreply; // see (R10)
        default: state_d = can_bsc_pkg::tx_idle; // see (R5) (R9)
      endcase
    end
  end

  // ----------------------------------------
  // Control word and engine view
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= `BSC_ST_RESET;
      pri_q <= `BSC_PRI_RESET;
      dlc_q <= `BSC_DLC_RESET;
      rx_accepting_q <= 1'b0;
      tx_request_q <= 1'b0;
      tx_bytes_q <= 4'h0;
    end else begin
      state_q <= state_d;
      pri_q <= pri_d;
      dlc_q <= dlc_d;
      rx_accepting_q <= is_rx_armed(state_d);
      tx_request_q <= is_tx_busy(state_d); // see (R11)
      tx_bytes_q <= tx_bytes_d; // see (R18)
    end
  end

  // ----------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------
  always_comb begin
    irq_ev = `BSC_IRQ_RESET;
    irq_ev[can_bsc_pkg::ev_rx_done] = rx_done_ok;
    irq_ev[can_bsc_pkg::ev_tx_done] = tx_done_ok;
    irq_ev[can_bsc_pkg::ev_wr_reject] = wr_reject;
    irq_clr = `BSC_IRQ_RESET;
    if (wr_fire && wr_addr_q == `BSC_OFS_IRQ_CLEAR && wr_strb_q[0]) begin
      irq_clr = wr_data_q[`BSC_IRQ_BITS-1:0];
    end
    // A new event wins over a clear in the same cycle
    irq_status_d = (irq_status_q & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= `BSC_IRQ_RESET;
      irq_enable_q <= `BSC_IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      if (wr_fire && wr_addr_q == `BSC_OFS_IRQ_ENABLE && wr_strb_q[0]) begin
        irq_enable_q <= wr_data_q[`BSC_IRQ_BITS-1:0];
      end
      irq_q <= |(irq_status_d & irq_enable_q);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rx_accepting = rx_accepting_q;
  assign tx_request = tx_request_q;
  assign tx_byte_count = tx_bytes_q;
  assign buffer_status_control = {dlc_q, 4'h0, pri_q, state_q}; // see (R1)
  assign irq = irq_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_busy_dlc_hold: assert property (@(posedge aclk) disable iff (!aresetn) // see (R3)
    (ctrl_wr && wr_strb_q[1] && busy && !eng_copy_done) |=> $stable(dlc_q))
    else $error("byte count changed by a write while busy");

  a_copy_start_code: assert property (@(posedge aclk) disable iff (!aresetn) // see (R6)
    (eng_copy_start && state_q == can_bsc_pkg::rx_armed) |=>
    state_q == can_bsc_pkg::rx_copy_first)
    else $error("first copy did not show 0011");

  a_copy_end_code: assert property (@(posedge aclk) disable iff (!aresetn) // see (R19)
    (eng_copy_done && state_q == can_bsc_pkg::rx_copy_first && !eng_copy_start) |=>
    state_q == can_bsc_pkg::rx_holding)
    else $error("first copy did not end in holding");

  a_update_clears: assert property (@(posedge aclk) disable iff (!aresetn) // see (R5)
    (tx_done_ok || rx_done_ok) |=> !state_q[`BSC_BUSY_BIT])
    else $error("engine update left busy set");

  a_autoreply_return: assert property (@(posedge aclk) disable iff (!aresetn) // see (R10)
    (tx_done_ok && state_q == can_bsc_pkg::tx_busy_autoreply) |=>
    state_q == can_bsc_pkg::tx_remote_autoreply && !tx_request)
    else $error("autoreply buffer not rearmed after send");

  a_no_rsvd_tx: assert property (@(posedge aclk) disable iff (!aresetn) // see (R13)
    state_q != can_bsc_pkg::tx_autoreply_busy_rsvd)
    else $error("reserved transmit state produced");

  a_tx_count_sat: assert property (@(posedge aclk) disable iff (!aresetn) // see (R18)
    dlc_q[3] ? (tx_byte_count == `BSC_DLC_MAX_BYTES) : (tx_byte_count == dlc_q))
    else $error("transmit byte count wrong");

  a_rx_count_back: assert property (@(posedge aclk) disable iff (!aresetn) // see (R16)
    rx_done_ok |=> dlc_q == $past(rx_bytes) && dlc_q <= `BSC_DLC_MAX_BYTES)
    else $error("received byte count not stored");

  a_pri_own: assert property (@(posedge aclk) disable iff (!aresetn) // see (R14)
    !(ctrl_wr && wr_strb_q[0]) |=> $stable(pri_q))
    else $error("priority changed without a write");

  a_sched_busy: assert property (@(posedge aclk) disable iff (!aresetn) // see (R11)
    (ctrl_wr && wr_strb_q[0] && !busy && wr_data_q[3:0] == 4'hC && !eng_copy_start
     && !eng_remote_hit) |=> tx_request)
    else $error("scheduled single shot not requested");

  c_rx_copy: cover property (@(posedge aclk) disable iff (!aresetn)
    state_q == can_bsc_pkg::rx_copy_first ##[1:20] state_q == can_bsc_pkg::rx_holding);
  c_tx_send: cover property (@(posedge aclk) disable iff (!aresetn)
    tx_request ##[1:20] tx_done_ok);
  c_reject: cover property (@(posedge aclk) disable iff (!aresetn) wr_reject ##2 irq);

endmodule
`default_nettype wire

/* File: dv/can_engine_model.sv */
// Behavioural protocol engine that drives copy, remote and transmit events
`timescale 1ns/1ps
`default_nettype none

module can_engine_model (
  // Clock
  input wire logic aclk,
  // Events towards the buffer
  output logic copy_start,
  output logic copy_done,
  output logic [3:0] rx_dlc,
  output logic remote_hit,
  output logic tx_done
);
  initial begin
    copy_start = 1'b0;
    copy_done = 1'b0;
    rx_dlc = 4'h5;
    remote_hit = 1'b0;
    tx_done = 1'b0;
  end

  // ----------------------------------------
  // Event pulse: 0 copy start, 1 copy done, 2 remote hit, 3 transmit done
  // ----------------------------------------
  // The gap lets the engine answer promptly or slowly
  task automatic pulse(input int sel, input int gap, input logic [3:0] dlc);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    copy_start <= (sel == 0);
    copy_done <= (sel == 1);
    remote_hit <= (sel == 2);
    tx_done <= (sel == 3);
    rx_dlc <= dlc;
    @(posedge aclk);
    copy_start <= 1'b0;
    copy_done <= 1'b0;
    remote_hit <= 1'b0;
    tx_done <= 1'b0;
    // Count lines no longer hold the last value once the pulse is over
    rx_dlc <= ~dlc;
  endtask
endmodule
`default_nettype wire

/* File: dv/can_buffer_status_control_tb_top.sv */
// Self-checking testbench of the buffer status/control block
`timescale 1ns/1ps
`default_nettype none

module can_buffer_status_control_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic cs, cd, rh, td, rx_acc, tx_req, irq;
  logic [3:0] rdlc, tx_cnt;
  logic [15:0] word;
  int num_errors = 0;
  int total_checks = 0;

  always #25 aclk = ~aclk;

  can_engine_model eng (.aclk(aclk), .copy_start(cs), .copy_done(cd), .rx_dlc(rdlc),
    .remote_hit(rh), .tx_done(td));

  can_buffer_status_control dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .eng_copy_start(cs), .eng_copy_done(cd), .eng_rx_dlc(rdlc), .eng_remote_hit(rh),
    .eng_tx_done(td), .rx_accepting(rx_acc), .tx_request(tx_req), .tx_byte_count(tx_cnt),
    .buffer_status_control(word), .irq(irq));

  // ----------------------------------------
  // Comparison, bus tasks and verdict
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er}, "write response");
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] mask,
      input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        rready <= 1'b0;
        check({30'h0, rresp}, {30'h0, er}, "read response");
        check(rdata & mask, ed, "read data");
      end
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Sequence takes under 2000 cycles; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    print_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
    rd(8'h0C, 32'h0, 32'hFFFFFFFF, 2'h0);
    wr(8'h0C, 32'h7, 4'hF, 2'h0);
    $display("test reset done");
    // Receive chain: armed, three copies, software abort during the last
    wr(8'h00, 32'h50A2, 4'h3, 2'h0);
    rd(8'h00, 32'h50A2, 32'hFFFFFFFF, 2'h0);
    check(word, 32'h50A2, "control word port");
    check(rx_acc, 1'b1, "accepting when armed");
    eng.pulse(0, 0, 4'h0);
    rd(8'h00, 32'h50A3, 32'hFFFF, 2'h0);
    wr(8'h00, 32'hF0A3, 4'h2, 2'h0);
    rd(8'h00, 32'h50A3, 32'hFFFF, 2'h0);
    rd(8'h04, 32'h4, 32'hFFFFFFFF, 2'h0);
    check(irq, 1'b1, "irq on reject");
    wr(8'h08, 32'h7, 4'hF, 2'h0);
    rd(8'h08, 32'h0, 32'hFFFFFFFF, 2'h0);
    rd(8'h04, 32'h0, 32'hFFFFFFFF, 2'h0);
    check(irq, 1'b0, "irq after clear");
    eng.pulse(1, 3, 4'hC);
    rd(8'h00, 32'h80A4, 32'hFFFF, 2'h0);
    rd(8'h04, 32'h1, 32'hFFFFFFFF, 2'h0);
    eng.pulse(0, 0, 4'h0);
    rd(8'h00, 32'h80A5, 32'hFFFF, 2'h0);
    eng.pulse(1, 0, 4'h3);
    rd(8'h00, 32'h30A6, 32'hFFFF, 2'h0);
    eng.pulse(0, 1, 4'h0);
    rd(8'h00, 32'h30A7, 32'hFFFF, 2'h0);
    check(rx_acc, 1'b0, "not accepting while copying");
    // Transmit idle written during a receive copy must not show 1001
    wr(8'h00, 32'h00A8, 4'h1, 2'h0);
    rd(8'h00, 32'h30A7, 32'hFFFF, 2'h0);
    wr(8'h00, 32'h00A0, 4'h1, 2'h0);
    rd(8'h00, 32'h30A1, 32'hFFFF, 2'h0);
    eng.pulse(1, 0, 4'h5);
    rd(8'h00, 32'hA0, 32'hFF, 2'h0);
    wr(8'h08, 32'h7, 4'hF, 2'h0);
    $display("test receive done");
    // Transmit: single shot, abort, autoreply, remote answer; tx done masked
    wr(8'h0C, 32'h5, 4'hF, 2'h0);
    wr(8'h00, 32'hF03C, 4'h3, 2'h0);
    rd(8'h00, 32'hF03D, 32'hFFFF, 2'h0);
    check(tx_req, 1'b1, "request while scheduled");
    check(tx_cnt, 4'h8, "byte count saturates");
    wr(8'h00, 32'h0038, 4'h1, 2'h0);
    rd(8'h00, 32'hF039, 32'hFFFF, 2'h0);
    eng.pulse(3, 0, 4'h0);
    rd(8'h00, 32'hF038, 32'hFFFF, 2'h0);
    check(tx_req, 1'b0, "no request when idle");
    eng.pulse(2, 0, 4'h0);
    rd(8'h00, 32'hF038, 32'hFFFF, 2'h0);
    wr(8'h00, 32'h003E, 4'h1, 2'h0);
    rd(8'h00, 32'hF03F, 32'hFFFF, 2'h0);
    eng.pulse(3, 4, 4'h0);
    rd(8'h00, 32'hF03A, 32'hFFFF, 2'h0);
    eng.pulse(2, 0, 4'h0);
    rd(8'h00, 32'hF03F, 32'hFFFF, 2'h0);
    eng.pulse(3, 0, 4'h0);
    rd(8'h00, 32'hF03A, 32'hFFFF, 2'h0);
    wr(8'h00, 32'h003B, 4'h1, 2'h0);
    rd(8'h00, 32'hF03A, 32'hFFFF, 2'h0);
    rd(8'h04, 32'h2, 32'hFFFFFFFF, 2'h0);
    check(irq, 1'b0, "masked event");
    wr(8'h0C, 32'h7, 4'hF, 2'h0);
    rd(8'h0C, 32'h7, 32'hFFFFFFFF, 2'h0);
    check(irq, 1'b1, "unmasked event");
    wr(8'h08, 32'h2, 4'hF, 2'h0);
    rd(8'h04, 32'h0, 32'hFFFFFFFF, 2'h0);
    check(irq, 1'b0, "cleared event");
    $display("test transmit done");
    // Every length code, and the unmapped address
    for (int d = 0; d < 16; d++) begin
      wr(8'h00, {16'h0, 4'(d), 12'h038}, 4'h3, 2'h0);
      rd(8'h00, {16'h0, 4'(d), 12'h038}, 32'hFFFFFFFF, 2'h0);
      check(tx_cnt, (d >= 8) ? 4'h8 : 4'(d), "byte count");
    end
    rd(8'h10, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(8'h10, 32'hFFFF, 4'hF, 2'h2);
    rd(8'h00, 32'hF038, 32'hFFFFFFFF, 2'h0);
    $display("test length and map done");
    // Mid-run reset while a send is pending and an event is flagged
    wr(8'h00, 32'h003C, 4'h1, 2'h0);
    wr(8'h00, 32'h103C, 4'h2, 2'h0);
    check(irq, 1'b1, "irq before reset");
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check(word, 32'h0, "word in reset");
    check({tx_req, irq}, 2'h0, "request and irq in reset");
    rd(8'h04, 32'h0, 32'hFFFFFFFF, 2'h0);
    rd(8'h0C, 32'h0, 32'hFFFFFFFF, 2'h0);
    rd(8'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
    $display("test reset in run done");
    print_verdict();
  end
endmodule
`default_nettype wire
